// [acsr_readout.sv]
/*
 Serial readout and power control of an 8-bit sampling converter: frame
 sequencing, output word shifting, abort, power-down and wake-up.
 Assumes the host drives frame select and serial clock slowly enough for
 mclk to see every edge, and that the sampled result arrives on
 sample_data from the analog side.
*/
`timescale 1ns/1ns
`include "acsr_cfg.svh"

// Behaviour
// - Frame select fall samples input, starts conversion.
// - Word: four zeros, eight bits MSB first, four zeros.
// - First zero at frame start; MSB on fourth fall.
// - Serial out floats on sixteenth falling edge.
// - Conversion completes on twelfth falling edge.
// - Acquisition starts at rise after eleventh fall.
// - Select high mid-conversion aborts, floats output.
// - Twelve-clock frame: float after LSB.
// - Rise between edges two and ten: power-down.
// - Over ten falls with select low wakes device.
// - Full power reached 0.8 us after wake.
module acsr_readout (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic                frame_sel_n_pin,
    input  wire logic                sclk_pin,
    input  wire acsr_pkg::acsr_result_t sample_data,
    output logic                     serial_out_o,
    output logic                     serial_out_oe,
    output logic                     sample_strobe,
    output logic                     conv_done,
    output logic                     acquiring,
    output logic                     powered_down,
    output logic                     fully_powered,
    output logic                     data_valid
);
    import acsr_pkg::*;

    acsr_edge_if edges ();

    acsr_sync u_sync (
        .mclk            (mclk),
        .rst_n           (rst_n),
        .frame_sel_n_pin (frame_sel_n_pin),
        .sclk_pin        (sclk_pin),
        .edges           (edges)
    );

    localparam acsr_edge_cnt_t MSB_EDGE   = 5'(`ACSR_MSB_EDGE);
    localparam acsr_edge_cnt_t ACQ_EDGE   = 5'(`ACSR_ACQ_EDGE);
    localparam acsr_edge_cnt_t CONV_EDGE  = 5'(`ACSR_CONV_EDGE);
    localparam acsr_edge_cnt_t FLOAT_EDGE = 5'(`ACSR_FLOAT_EDGE);
    localparam acsr_edge_cnt_t PD_LO      = 5'(`ACSR_PD_LO_EDGE);
    localparam acsr_edge_cnt_t PD_HI      = 5'(`ACSR_PD_HI_EDGE);
    localparam acsr_edge_cnt_t WAKE_EDGE  = 5'(`ACSR_WAKE_EDGE);
    localparam logic [3:0]     PWRUP_CYC  = 4'(`ACSR_PWRUP_CYC);

    acsr_state_t    state_reg;
    acsr_edge_cnt_t edge_cnt_reg;
    acsr_result_t   result_reg;
    logic [15:0]    shift_reg;
    logic           out_reg;
    logic           oe_reg;
    logic           acq_pending_reg;
    logic           acq_reg;
    logic           done_reg;
    logic           strobe_reg;
    logic           valid_reg;
    logic           prev_ok_reg;
    logic [3:0]     pwr_cnt_reg;
    logic           pwr_ok_reg;

    // ------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= ACSR_IDLE;
        end else begin
            unique case (state_reg)
                ACSR_IDLE: begin
                    if (edges.frame_fall) begin
                        state_reg <= ACSR_FRAME;
                    end
                end
                ACSR_FRAME: begin
                    if (edges.frame_rise) begin
                        if (edge_cnt_reg >= PD_LO &&
                            edge_cnt_reg < PD_HI) begin
                            state_reg <= ACSR_POWERDOWN;
                        end else begin
                            state_reg <= ACSR_IDLE;
                        end
                    end
                end
                ACSR_POWERDOWN: begin
                    if (edges.frame_fall) begin
                        state_reg <= ACSR_WAKE;
                    end
                end
                ACSR_WAKE: begin
                    if (edges.frame_rise) begin
                        if (edge_cnt_reg > WAKE_EDGE) begin
                            state_reg <= ACSR_IDLE;
                        end else begin
                            state_reg <= ACSR_POWERDOWN;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Serial clock falling edge count within a frame
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            edge_cnt_reg <= 5'h0;
        end else if (edges.frame_fall) begin
            edge_cnt_reg <= 5'h0;
        end else if (edges.sclk_fall && !edges.frame_sel_n &&
                     edge_cnt_reg != 5'h1f) begin
            edge_cnt_reg <= edge_cnt_reg + 5'h1;
        end
    end

    // ------------------------------------------------------------------
    // Sample capture and output word
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            result_reg <= `ACSR_RESULT_RST;
            shift_reg  <= 16'h0000;
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= 1'b0;
            if (edges.frame_fall && state_reg == ACSR_IDLE) begin
                result_reg <= sample_data;
                strobe_reg <= 1'b1;
                // Word already stripped of its first zero, which goes
                // out at the frame start itself.
                shift_reg  <= {3'h0, sample_data, 5'h00};
            end else if (state_reg == ACSR_FRAME && edges.sclk_fall) begin
                shift_reg <= {shift_reg[14:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial out driver
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            out_reg <= 1'b0;
            oe_reg  <= 1'b0;
        end else if (edges.frame_fall && state_reg == ACSR_IDLE) begin
            out_reg <= 1'b0;
            oe_reg  <= 1'b1;
        end else if (state_reg != ACSR_FRAME || edges.frame_rise) begin
            out_reg <= 1'b0;
            oe_reg  <= 1'b0;
        end else if (edges.sclk_fall) begin
            if (edge_cnt_reg + 5'h1 == FLOAT_EDGE) begin
                out_reg <= 1'b0;
                oe_reg  <= 1'b0;
            end else begin
                out_reg <= shift_reg[15];
            end
        end
    end

    // ------------------------------------------------------------------
    // Conversion and acquisition phase
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            done_reg        <= 1'b0;
            acq_pending_reg <= 1'b0;
            acq_reg         <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (state_reg != ACSR_FRAME || edges.frame_rise) begin
                acq_pending_reg <= 1'b0;
                if (state_reg == ACSR_FRAME && !acq_reg) begin
                    acq_reg <= 1'b0;
                end
            end else begin
                if (edges.sclk_fall && edge_cnt_reg + 5'h1 == ACQ_EDGE) begin
                    acq_pending_reg <= 1'b1;
                end
                if (acq_pending_reg && edges.sclk_rise) begin
                    acq_reg         <= 1'b1;
                    acq_pending_reg <= 1'b0;
                end
                if (edges.sclk_fall && edge_cnt_reg + 5'h1 == CONV_EDGE) begin
                    done_reg <= 1'b1;
                end
            end
            if (edges.frame_fall) begin
                acq_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Power-up timer and result validity
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pwr_cnt_reg <= 4'h0;
            pwr_ok_reg  <= 1'b1;
        end else if (state_reg == ACSR_POWERDOWN) begin
            pwr_ok_reg  <= 1'b0;
            pwr_cnt_reg <= 4'h0;
        end else if (!pwr_ok_reg) begin
            if (pwr_cnt_reg + 4'h1 >= PWRUP_CYC) begin
                pwr_ok_reg <= 1'b1;
            end else begin
                pwr_cnt_reg <= pwr_cnt_reg + 4'h1;
            end
        end
    end

    // A frame carries valid data only when the previous frame reached
    // its acquisition point and the device is fully powered. This flag
    // lets the host side skip the first result after a wake.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prev_ok_reg <= 1'b0;
            valid_reg   <= 1'b0;
        end else begin
            if (edges.frame_fall && state_reg == ACSR_IDLE) begin
                valid_reg <= prev_ok_reg && pwr_ok_reg;
            end
            if (state_reg == ACSR_FRAME && edges.frame_rise) begin
                prev_ok_reg <= acq_reg;
            end
            if (state_reg == ACSR_POWERDOWN || state_reg == ACSR_WAKE) begin
                prev_ok_reg <= 1'b0;
            end
        end
    end

    assign serial_out_o  = out_reg;
    assign serial_out_oe = oe_reg;
    assign sample_strobe = strobe_reg;
    assign conv_done     = done_reg;
    assign acquiring     = acq_reg;
    assign powered_down  = (state_reg == ACSR_POWERDOWN);
    assign fully_powered = pwr_ok_reg;
    assign data_valid    = valid_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    frame_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (edges.frame_fall && state_reg == ACSR_IDLE) |=>
            sample_strobe && serial_out_oe && !serial_out_o)
        else $error("frame start did not drive first zero");

    msb_edge_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_reg == ACSR_FRAME && edges.sclk_fall && !edges.frame_rise &&
         edge_cnt_reg == 5'h3) |=> serial_out_o == result_reg[7])
        else $error("msb not on fourth falling edge");

    trail_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (serial_out_oe && edge_cnt_reg >= 5'hc) |-> !serial_out_o)
        else $error("trailing bit not zero");

    float_16_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_reg == ACSR_FRAME && edges.sclk_fall &&
         edge_cnt_reg == 5'hf) |=> !serial_out_oe)
        else $error("output not floated on sixteenth edge");

    conv_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
        conv_done |-> $past(edge_cnt_reg) == 5'hb)
        else $error("conversion ended on wrong edge");

    acq_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(acquiring) |-> edge_cnt_reg == ACQ_EDGE && $past(edges.sclk_rise))
        else $error("acquisition started at wrong point");

    abort_float_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_reg == ACSR_FRAME && edges.frame_rise) |=> !serial_out_oe)
        else $error("abort did not float output");

    pd_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_reg == ACSR_FRAME && edges.frame_rise &&
         edge_cnt_reg >= 5'h2 && edge_cnt_reg < 5'ha) |=> powered_down)
        else $error("power-down not entered");

    power_up_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(powered_down) |-> !fully_powered ##[1:9] fully_powered)
        else $error("power-up time wrong");

    idle_float_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_reg == ACSR_IDLE && !edges.frame_fall) |=>
            !serial_out_oe && $stable(edge_cnt_reg))
        else $error("output driven or count moved while idle");
endmodule // acsr_readout

// [acsr_cfg.svh]
/*
 Timing constants, output word layout and counts for the serial readout
 and power-control block of an 8-bit sampling converter.
 Assumes it is included by its bare name in every file that needs it.
*/
`ifndef ACSR_CFG_SVH
`define ACSR_CFG_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define ACSR_MCLK_NS        100
`define ACSR_PWRUP_NS       800
// Least time: rounds up to whole cycles.
`define ACSR_PWRUP_CYC      ((`ACSR_PWRUP_NS + `ACSR_MCLK_NS - 1) / `ACSR_MCLK_NS)

// ----------------------------------------------------------------------
// Word layout and edge numbers
// ----------------------------------------------------------------------
`define ACSR_LEAD_ZEROS     4
`define ACSR_RES_BITS       8
`define ACSR_TRAIL_ZEROS    4
`define ACSR_MSB_EDGE       4
`define ACSR_ACQ_EDGE       11
`define ACSR_CONV_EDGE      12
`define ACSR_FLOAT_EDGE     16
`define ACSR_PD_LO_EDGE     2
`define ACSR_PD_HI_EDGE     10
`define ACSR_WAKE_EDGE      10
`define ACSR_RESULT_RST     8'h00

`endif

// [acsr_pkg.sv]
/*
 Types shared by the serial readout block and its edge synchroniser.
 Assumes acsr_cfg.svh is on the include path.
*/
package acsr_pkg;
    typedef logic [7:0] acsr_result_t;
    typedef logic [4:0] acsr_edge_cnt_t;
    typedef enum logic [1:0] {
        ACSR_IDLE,
        ACSR_FRAME,
        ACSR_POWERDOWN,
        ACSR_WAKE
    } acsr_state_t;
endpackage

// [acsr_edge_if.sv]
/*
 Carries the synchronised frame select and serial clock edges from the
 synchroniser to the readout logic.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
interface acsr_edge_if;
    logic frame_sel_n;
    logic frame_fall;
    logic frame_rise;
    logic sclk_fall;
    logic sclk_rise;
    modport src (output frame_sel_n, frame_fall, frame_rise,
                 sclk_fall, sclk_rise);
    modport dst (input  frame_sel_n, frame_fall, frame_rise,
                 sclk_fall, sclk_rise);
endinterface

// [acsr_sync.sv]
/*
 Two-flop synchronisers and edge detectors for the frame select and the
 serial clock pins.
 Assumes the pins are asynchronous to mclk and much slower than it.
*/
`timescale 1ns/1ns
module acsr_sync (
    input  wire logic   mclk,
    input  wire logic   rst_n,
    input  wire logic   frame_sel_n_pin,
    input  wire logic   sclk_pin,
    acsr_edge_if.src    edges
);
    import acsr_pkg::*;

    logic [1:0] cs_sync_reg;
    logic [1:0] sc_sync_reg;
    logic       cs_last_reg;
    logic       sc_last_reg;

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            // The serial clock rests high between frames, so its chain is
            // preset high too; a low preset would show a false rising edge.
            cs_sync_reg <= 2'h3;
            sc_sync_reg <= 2'h3;
            cs_last_reg <= 1'b1;
            sc_last_reg <= 1'b1;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], frame_sel_n_pin};
            sc_sync_reg <= {sc_sync_reg[0], sclk_pin};
            cs_last_reg <= cs_sync_reg[1];
            sc_last_reg <= sc_sync_reg[1];
        end
    end

    assign edges.frame_sel_n = cs_sync_reg[1];
    assign edges.frame_fall  = cs_last_reg & ~cs_sync_reg[1];
    assign edges.frame_rise  = ~cs_last_reg & cs_sync_reg[1];
    assign edges.sclk_fall   = sc_last_reg & ~sc_sync_reg[1];
    assign edges.sclk_rise   = ~sc_last_reg & sc_sync_reg[1];
endmodule // acsr_sync

// [acsr_host_model.sv]
/*
 Host serial master model for the converter readout block: drives frame
 select and serial clock, and samples serial out after each falling edge.
 Assumes mclk runs at 100 ns; the serial clock period is 8 mclk (800 ns).
*/
`timescale 1ns/1ns
module acsr_host_model (
    input  wire logic mclk,
    input  wire logic serial_out_o,
    input  wire logic serial_out_oe,
    output logic      frame_sel_n,
    output logic      sclk
);
    // ------------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------------
    logic bit_seen [0:16];
    logic oe_seen  [0:16];
    logic oe_end;
    logic oe_any;

    // The serial clock rests high between frames, as a real host would.
    initial begin
        frame_sel_n = 1'b1;
        sclk        = 1'b1;
        oe_end      = 1'b0;
        oe_any      = 1'b0;
    end

    task automatic wait_mclk(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic look(input int k);
        bit_seen[k] = serial_out_o;
        oe_seen[k]  = serial_out_oe;
    endtask

    // Samples 6 mclk after each fall, well after the pin has settled.
    task automatic run_frame(input int nclk);
        wait_mclk(1);
        frame_sel_n = 1'b0;
        wait_mclk(6);
        look(0);
        for (int n = 1; n <= nclk; n++) begin
            sclk = 1'b0;
            wait_mclk(4);
            sclk = 1'b1;
            wait_mclk(2);
            look(n);
            wait_mclk(2);
        end
        frame_sel_n = 1'b1;
        wait_mclk(6);
        oe_end = serial_out_oe;
        wait_mclk(4);
    endtask

    task automatic idle_clk(input int n);
        oe_any = 1'b0;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            wait_mclk(4);
            sclk = 1'b1;
            wait_mclk(4);
            oe_any = oe_any | serial_out_oe;
        end
    endtask
endmodule // acsr_host_model

// [acsr_readout_tb.sv]
/*
 Self-checking testbench for the serial readout and power-control block.
 Assumes the design modules and acsr_host_model are compiled before it.
*/
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("mismatch %s expected %h seen %h", nm, exp, \
    got); end end
module acsr_readout_tb;
    import acsr_pkg::*;
    // ------------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------------
    logic         mclk;
    logic         rst_n;
    logic         frame_sel_n;
    logic         sclk;
    acsr_result_t sample_data;
    logic         serial_out_o;
    logic         serial_out_oe;
    logic         sample_strobe;
    logic         conv_done;
    logic         acquiring;
    logic         powered_down;
    logic         fully_powered;
    logic         data_valid;
    int           n_mismatch;
    int           checks;
    int           n_strobe;
    int           n_done;
    int           cycles;

    acsr_readout DUT (.mclk(mclk), .rst_n(rst_n),
        .frame_sel_n_pin(frame_sel_n), .sclk_pin(sclk),
        .sample_data(sample_data), .serial_out_o(serial_out_o),
        .serial_out_oe(serial_out_oe), .sample_strobe(sample_strobe),
        .conv_done(conv_done), .acquiring(acquiring),
        .powered_down(powered_down), .fully_powered(fully_powered),
        .data_valid(data_valid));

    acsr_host_model host (.mclk(mclk), .serial_out_o(serial_out_o),
        .serial_out_oe(serial_out_oe), .frame_sel_n(frame_sel_n),
        .sclk(sclk));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Pulse counters, cleared by frame_word before each frame it runs.
    always @(posedge mclk) begin
        cycles++;
        if (sample_strobe === 1'b1) n_strobe++;
        if (conv_done === 1'b1) n_done++;
        if (cycles == 8000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic frame_word(input acsr_result_t d, input int nclk);
        logic e;
        sample_data = d;
        n_strobe = 0;
        n_done = 0;
        host.run_frame(nclk);
        for (int k = 0; k <= nclk && k < 16; k++) begin
            e = (k >= 4 && k <= 11) ? d[11-k] : 1'b0;
            `CHK("word bit", e, host.bit_seen[k])
            `CHK("bit drive", 1'b1, host.oe_seen[k])
        end
        `CHK("sample pulse", 1, n_strobe)
    endtask

    task automatic t_idle();
        `CHK("reset oe", 1'b0, serial_out_oe)
        `CHK("reset pd", 1'b0, powered_down)
        `CHK("reset power", 1'b1, fully_powered)
        host.idle_clk(3);
        `CHK("idle oe", 1'b0, host.oe_any)
        `CHK("idle sample", 0, n_strobe)
    endtask

    task automatic t_full(input acsr_result_t d, input int valid);
        frame_word(d, 16);
        `CHK("float at 16", 1'b0, host.oe_seen[16])
        `CHK("conv done", 1, n_done)
        `CHK("acquiring", 1'b1, acquiring)
        if (valid >= 0)
            `CHK("data valid", logic'(valid[0]), data_valid)
    endtask

    task automatic t_short(input acsr_result_t d);
        frame_word(d, 12);
        `CHK("short float", 1'b0, host.oe_end)
        `CHK("short done", 1, n_done)
    endtask

    task automatic t_abort(input int nclk, input logic acq);
        frame_word(8'hFF, nclk);
        `CHK("abort float", 1'b0, host.oe_end)
        `CHK("abort done", 0, n_done)
        `CHK("abort acq", acq, acquiring)
        `CHK("abort no pd", 1'b0, powered_down)
        t_full(8'h3C, int'(acq));
    endtask

    task automatic t_pd(input int nclk);
        int w;
        host.run_frame(nclk);
        `CHK("pd entered", 1'b1, powered_down)
        `CHK("pd float", 1'b0, host.oe_end)
        `CHK("pd power", 1'b0, fully_powered)
        host.run_frame(10);
        `CHK("short wake", 1'b1, powered_down)
        host.run_frame(11);
        `CHK("wake no drive", 1'b0, host.oe_seen[0])
        `CHK("woken", 1'b0, powered_down)
        w = 0;
        while (fully_powered !== 1'b1 && w < 20) begin
            @(negedge mclk);
            w++;
        end
        `CHK("powered up", 1'b1, fully_powered)
        t_full(8'h96, 0);
        t_full(8'h69, 1);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        sample_data = 8'h00;
        n_mismatch = 0;
        checks = 0;
        cycles = 0;
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_idle();
        t_full(8'hA5, 0);
        t_full(8'h5A, 1);
        t_short(8'h81);
        t_abort(11, 1'b1);
        t_abort(10, 1'b0);
        t_abort(1, 1'b0);
        t_pd(2);
        t_pd(9);
        close_out();
    end
endmodule // acsr_readout_tb
